// *** hw/eac_defs.vh ***
`ifndef EAC_DEFS_VH
`define EAC_DEFS_VH

// ==========================================
// register map, data-space byte addresses
`define EAC_ADDR_CONTROL   8'h3f
`define EAC_ADDR_DATA      8'h40
`define EAC_ADDR_ADDR_LO   8'h41
`define EAC_ADDR_ADDR_HI   8'h42

// ==========================================
// address space layout
`define EAC_IO_OFFSET      8'h20
`define EAC_IO_LIMIT       8'h40
`define EAC_BIT_LIMIT      8'h20
`define EAC_EXT_BASE       8'h60

// ==========================================
// control field positions
`define EAC_B_READ         0
`define EAC_B_STROBE       1
`define EAC_B_ARM          2
`define EAC_B_IRQ_EN       3
`define EAC_B_MODE_LO      4
`define EAC_B_MODE_HI      5
`define EAC_B_DONE         7

// ==========================================
// programming action codes
`define EAC_MODE_ATOMIC    2'h0
`define EAC_MODE_ERASE     2'h1
`define EAC_MODE_WRITE     2'h2
`define EAC_MODE_RSVD      2'h3

// ==========================================
// reset values and constants
`define EAC_RST_BYTE       8'h00
`define EAC_ERASED_BYTE    8'hff
`define EAC_ADDR_HI_MASK   8'h03
`define EAC_FULL_MASK      8'hff
`define EAC_ONE_BIT        8'h01

// ==========================================
// timing
`define EAC_CLK_MHZ        200
`define EAC_T_ATOMIC_US    3400
`define EAC_T_SPLIT_US     1800
`define EAC_OSC_DIV        25
`define EAC_READ_STALL     3'h4
`define EAC_WRITE_STALL    3'h2
`define EAC_ARM_WINDOW     3'h4

`endif

// *** hw/eac_prog_timer.v ***
`include "eac_defs.vh"

module eac_prog_timer #(
  parameter DIV_W = 8,
  parameter CNT_W = 20,
  parameter [DIV_W-1:0] OSC_DIV = `EAC_OSC_DIV
) (
  input  wire             clock,
  input  wire             por,
  input  wire             start,
  input  wire [CNT_W-1:0] ticks,
  output reg              done
);

  // ==========================================
  // oscillator tick divider
  reg [DIV_W-1:0] div_cnt;
  reg             tick;
  reg [CNT_W-1:0] remain;
  reg             running;

  always @(posedge clock or posedge por) begin
    if (por) begin
      div_cnt <= {DIV_W{1'b0}};
      tick    <= 1'b0;
    end else if (start || div_cnt == OSC_DIV - 1'b1) begin
      div_cnt <= {DIV_W{1'b0}};
      tick    <= ~start;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // ==========================================
  // tick counter; only por stops it so a cpu reset lets it finish
  always @(posedge clock or posedge por) begin
    if (por) begin
      remain  <= {CNT_W{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain  <= ticks;
        running <= 1'b1;
      end else if (running && tick) begin
        if (remain <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end

endmodule

// *** hw/eac_nv_access.v ***
`include "eac_defs.vh"

module eac_nv_access #(
  parameter DEPTH = 1024,
  parameter AW    = 10,
  parameter [7:0] OSC_DIV = `EAC_OSC_DIV,
  parameter [19:0] ATOMIC_TICKS = `EAC_T_ATOMIC_US * `EAC_CLK_MHZ / `EAC_OSC_DIV,
  parameter [19:0] SPLIT_TICKS  = `EAC_T_SPLIT_US * `EAC_CLK_MHZ / `EAC_OSC_DIV
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       por,
  input  wire [7:0] cpu_addr,
  input  wire       cpu_io_space,
  input  wire       cpu_wr,
  input  wire       cpu_rd,
  input  wire [7:0] cpu_wdata,
  input  wire       cpu_bit_set,
  input  wire       cpu_bit_clr,
  input  wire       cpu_bit_test,
  input  wire [2:0] cpu_bit_sel,
  input  wire       global_irq_enable,
  output reg  [7:0] cpu_rdata,
  output reg        bit_test_hit,
  output reg        cpu_stall,
  output reg        nv_ready_irq
);

  // ==========================================
  // address decode
  reg [7:0] eff_addr;
  reg       addr_ok;
  reg       bit_ok;

  always @* begin
    eff_addr = cpu_addr;
    addr_ok  = 1'b1;
    bit_ok   = 1'b0;
    if (cpu_io_space) begin
      eff_addr = cpu_addr + `EAC_IO_OFFSET;
      addr_ok  = (cpu_addr < `EAC_IO_LIMIT);
      bit_ok   = (cpu_addr < `EAC_BIT_LIMIT);
    end
  end

  wire is_ctrl = addr_ok && eff_addr == `EAC_ADDR_CONTROL;
  wire is_data = addr_ok && eff_addr == `EAC_ADDR_DATA;
  wire is_alo  = addr_ok && eff_addr == `EAC_ADDR_ADDR_LO;
  wire is_ahi  = addr_ok && eff_addr == `EAC_ADDR_ADDR_HI;

  // ==========================================
  // write mask and value; bit ops touch one bit only
  reg [7:0] wmask;
  reg [7:0] wval;

  always @* begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (cpu_wr) begin
      wmask = `EAC_FULL_MASK;
      wval  = cpu_wdata;
    end else if (bit_ok && (cpu_bit_set || cpu_bit_clr)) begin
      wmask = `EAC_ONE_BIT << cpu_bit_sel;
      wval  = cpu_bit_set ? `EAC_FULL_MASK : 8'h00;
    end
  end

  wire any_wr = cpu_wr || (bit_ok && (cpu_bit_set || cpu_bit_clr));

  // ==========================================
  // state
  reg [7:0]    nv_byte_data;
  reg [AW-1:0] nv_byte_address;
  reg [1:0]    program_action_select;
  reg          write_busy_strobe;
  reg          write_arm_enable;
  reg          ready_irq_enable;
  reg          done_flag;
  reg [2:0]    arm_left;
  reg [2:0]    stall_left;
  reg [1:0]    op_mode;
  reg [AW-1:0] op_addr;
  reg [7:0]    op_data;
  reg          rst_s1;
  reg          rst_s2;
  reg [7:0]    cells [0:DEPTH-1];

  wire [7:0] ctrl_view = {done_flag, 1'b0, program_action_select, ready_irq_enable,
                          write_arm_enable, write_busy_strobe, 1'b0};

  wire ctrl_wr    = any_wr && is_ctrl;
  wire read_go    = ctrl_wr && wmask[`EAC_B_READ] && wval[`EAC_B_READ]
                    && !write_busy_strobe;
  wire strobe_req = ctrl_wr && wmask[`EAC_B_STROBE] && wval[`EAC_B_STROBE];
  wire write_go   = strobe_req && write_arm_enable && !write_busy_strobe
                    && program_action_select != `EAC_MODE_RSVD;
  wire arm_set    = ctrl_wr && wmask[`EAC_B_ARM] && wval[`EAC_B_ARM];
  wire arm_clr    = ctrl_wr && wmask[`EAC_B_ARM] && !wval[`EAC_B_ARM];
  wire done_clr   = ctrl_wr && wmask[`EAC_B_DONE] && wval[`EAC_B_DONE];
  wire prog_done;

  wire [19:0] load_ticks = (program_action_select == `EAC_MODE_ATOMIC) ?
                           ATOMIC_TICKS : SPLIT_TICKS;

  // ==========================================
  // self-timed programming counter
  eac_prog_timer #(
    .DIV_W   (8),
    .CNT_W   (20),
    .OSC_DIV (OSC_DIV)
  ) u_timer (
    .clock (clock),
    .por   (por),
    .start (write_go),
    .ticks (load_ticks),
    .done  (prog_done)
  );

  // ==========================================
  // reset seen by the engine, synchronised
  always @(posedge clock or posedge por) begin
    if (por) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= rst;
      rst_s2 <= rst_s1;
    end
  end

  // ==========================================
  // programming engine, power-on resets it; the synchronised reset only clears the mode select when idle
  always @(posedge clock or posedge por) begin
    if (por) begin
      write_busy_strobe     <= 1'b0;
      program_action_select <= `EAC_MODE_ATOMIC;
      nv_byte_address       <= {AW{1'b0}};
      op_mode               <= `EAC_MODE_ATOMIC;
      op_addr               <= {AW{1'b0}};
      op_data               <= `EAC_RST_BYTE;
    end else begin
      if (write_go) begin
        write_busy_strobe <= 1'b1;
        op_mode           <= program_action_select;
        op_addr           <= nv_byte_address;
        op_data           <= nv_byte_data;
      end else if (prog_done) begin
        write_busy_strobe <= 1'b0;
      end
      if (rst_s2) begin
        if (!write_busy_strobe) begin
          program_action_select <= `EAC_MODE_ATOMIC;
        end
      end else if (ctrl_wr && !write_busy_strobe) begin
        if (wmask[`EAC_B_MODE_LO]) begin
          program_action_select[0] <= wval[`EAC_B_MODE_LO];
        end
        if (wmask[`EAC_B_MODE_HI]) begin
          program_action_select[1] <= wval[`EAC_B_MODE_HI];
        end
      end
      // address frozen while programming
      if (any_wr && !write_busy_strobe && !rst_s2) begin
        if (is_alo) begin
          nv_byte_address[7:0] <= (nv_byte_address[7:0] & ~wmask) | (wval & wmask);
        end
        if (is_ahi) begin
          nv_byte_address[AW-1:8] <= (nv_byte_address[AW-1:8] & ~wmask[AW-9:0])
                                     | (wval[AW-9:0] & wmask[AW-9:0]);
        end
      end
    end
  end

  // ==========================================
  // cell array: erase sets ones, write only pulls bits low
  // cells start uninitialised, as after power-up
  always @(posedge clock) begin
    if (prog_done) begin
      case (op_mode)
        `EAC_MODE_ATOMIC: begin
          cells[op_addr] <= op_data;
        end
        `EAC_MODE_ERASE: begin
          cells[op_addr] <= `EAC_ERASED_BYTE;
        end
        `EAC_MODE_WRITE: begin
          cells[op_addr] <= cells[op_addr] & op_data;
        end
        default: begin
          cells[op_addr] <= cells[op_addr];
        end
      endcase
    end
  end

  // ==========================================
  // cpu-side registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      nv_byte_data     <= `EAC_RST_BYTE;
      write_arm_enable <= 1'b0;
      arm_left         <= 3'h0;
      ready_irq_enable <= 1'b0;
      done_flag        <= 1'b0;
      stall_left       <= 3'h0;
      cpu_stall        <= 1'b0;
      cpu_rdata        <= `EAC_RST_BYTE;
      bit_test_hit     <= 1'b0;
      nv_ready_irq     <= 1'b0;
    end else begin
      if (read_go) begin
        nv_byte_data <= cells[nv_byte_address];
      end else if (any_wr && is_data) begin
        nv_byte_data <= (nv_byte_data & ~wmask) | (wval & wmask);
      end
      // arm window: open four cycles, then hardware drops it
      // a strobe on the fourth cycle still counts
      if (arm_set) begin
        write_arm_enable <= 1'b1;
        arm_left         <= `EAC_ARM_WINDOW - 3'h1;
      end else if (arm_clr || write_go) begin
        write_arm_enable <= 1'b0;
      end else if (write_arm_enable) begin
        if (arm_left == 3'h0) begin
          write_arm_enable <= 1'b0;
        end else begin
          arm_left <= arm_left - 3'h1;
        end
      end
      if (ctrl_wr && wmask[`EAC_B_IRQ_EN]) begin
        ready_irq_enable <= wval[`EAC_B_IRQ_EN];
      end
      // set wins over a write-one clear in the same cycle
      if (prog_done) begin
        done_flag <= 1'b1;
      end else if (done_clr) begin
        done_flag <= 1'b0;
      end
      // stall counts from the edge that takes the strobe
      if (read_go) begin
        stall_left <= `EAC_READ_STALL - 3'h1;
        cpu_stall  <= 1'b1;
      end else if (write_go) begin
        stall_left <= `EAC_WRITE_STALL - 3'h1;
        cpu_stall  <= 1'b1;
      end else if (stall_left != 3'h0) begin
        stall_left <= stall_left - 3'h1;
      end else begin
        cpu_stall <= 1'b0;
      end
      // unmapped and short-io extended reads return zero
      if (cpu_rd) begin
        if (is_ctrl) begin
          cpu_rdata <= ctrl_view;
        end else if (is_data) begin
          cpu_rdata <= nv_byte_data;
        end else if (is_alo) begin
          cpu_rdata <= nv_byte_address[7:0];
        end else if (is_ahi) begin
          cpu_rdata <= {{(16-AW){1'b0}}, nv_byte_address[AW-1:8]};
        end else begin
          cpu_rdata <= 8'h00;
        end
      end
      if (cpu_bit_test) begin
        bit_test_hit <= bit_ok && is_ctrl && ctrl_view[cpu_bit_sel];
      end
      // one cycle late, so the output comes straight from a flop
      nv_ready_irq <= ready_irq_enable && global_irq_enable
                      && !write_busy_strobe;
    end
  end

endmodule

// *** test/eac_cpu.sv ***
// ==========================================
// cpu core: halts while stalled
module eac_cpu (
  input  wire        clock,
  input  wire        cpu_stall,
  input  wire  [7:0] cpu_rdata,
  output logic [7:0] cpu_addr,
  output logic       cpu_io_space,
  output logic       cpu_wr,
  output logic       cpu_rd,
  output logic [7:0] cpu_wdata,
  output logic       cpu_bit_set,
  output logic       cpu_bit_clr,
  output logic       cpu_bit_test,
  output logic [2:0] cpu_bit_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  int stall_n;
  initial begin
    {cpu_addr, cpu_io_space, cpu_wdata, cpu_bit_sel} = 20'h00000;
    {cpu_wr, cpu_rd, cpu_bit_set, cpu_bit_clr, cpu_bit_test} = 5'h00;
  end
  // kind 0 write, 1 read, 2 set, 3 clear, 4 test
  task automatic op(input int k, input logic io, input logic [7:0] a, d);
    while (cpu_stall) @(negedge clock);
    {cpu_io_space, cpu_addr, cpu_wdata, cpu_bit_sel} = {io, a, d, d[2:0]};
    {cpu_wr, cpu_rd, cpu_bit_set, cpu_bit_clr, cpu_bit_test} = 5'h10 >> k;
    @(negedge clock);
    {cpu_wr, cpu_rd, cpu_bit_set, cpu_bit_clr, cpu_bit_test} = 5'h00;
    // idle lines toggle, a stale value never looks valid
    {cpu_addr, cpu_wdata} = ~{a, d};
    // halted cycles counted here; an idle cycle keeps two strobes apart
    stall_n = 0;
    while (cpu_stall && stall_n < 20) begin
      stall_n++;
      @(negedge clock);
    end
    if (stall_n == 0) @(negedge clock);
  endtask
  task automatic rd(input logic io, input logic [7:0] a, output logic [7:0] v);
    op(1, io, a, 8'h00);
    @(negedge clock);
    v = cpu_rdata;
  endtask
  task automatic prog(input logic [9:0] ad, input logic [7:0] d, input logic [1:0] m);
    op(0, 1'b0, 8'h42, {6'h00, ad[9:8]});
    op(0, 1'b0, 8'h41, ad[7:0]);
    op(0, 1'b0, 8'h40, d);
    op(0, 1'b1, 8'h1f, {2'h0, m, 4'h0});
    op(2, 1'b1, 8'h1f, 8'h02);
    op(2, 1'b1, 8'h1f, 8'h01);
  endtask
endmodule

// *** test/eac_nv_access_sva.sv ***
// ==========================================
// port checks of the access controller
module eac_nv_access_sva (
  input wire       clock,
  input wire       rst,
  input wire       por,
  input wire [7:0] cpu_addr,
  input wire       cpu_io_space,
  input wire       cpu_wr,
  input wire       cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire       cpu_bit_set,
  input wire [2:0] cpu_bit_sel,
  input wire       global_irq_enable,
  input wire [7:0] cpu_rdata,
  input wire       cpu_stall,
  input wire       nv_ready_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst || por);
  wire ctl = cpu_io_space ? cpu_addr == 8'h1f : cpu_addr == 8'h3f;
  wire hi  = cpu_io_space ? cpu_addr == 8'h22 : cpu_addr == 8'h42;
  wire arm = ctl && (cpu_bit_set && cpu_bit_sel == 3'h2 || cpu_wr && cpu_wdata[2]);
  wire stb = ctl && cpu_bit_set && cpu_bit_sel == 3'h1;
  wire rds = ctl && cpu_bit_set && cpu_bit_sel == 3'h0;
  // saturates so a long-gone arm never counts
  logic [2:0] age;
  always @(posedge clock or posedge rst or posedge por) begin
    if (rst || por) age <= 3'h7;
    else if (arm) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  a_read_stall: assert property (
    $rose(cpu_stall) && $past(rds) |-> cpu_stall[*4] ##1 !cpu_stall)
    else $error("bad read stall");
  a_write_stall: assert property (
    $rose(cpu_stall) && $past(stb) |-> cpu_stall[*2] ##1 !cpu_stall ##1 !nv_ready_irq)
    else $error("bad write stall");
  a_stall_cause: assert property (
    $rose(cpu_stall) |-> $past(ctl && (cpu_bit_set || cpu_wr)))
    else $error("stall without strobe");
  a_no_arm: assert property (
    stb && !cpu_stall && age > 3'h3 |=> !cpu_stall)
    else $error("strobe started unarmed");
  a_rdata_hold: assert property (
    !$past(cpu_rd) |-> $stable(cpu_rdata))
    else $error("read data moved");
  a_irq_gate: assert property (
    nv_ready_irq |-> $past(global_irq_enable))
    else $error("irq while gated");
  a_ext_io: assert property (
    cpu_rd && cpu_io_space && cpu_addr >= 8'h40 |=> cpu_rdata == 8'h00)
    else $error("short io reached ext");
  a_ctrl_rsvd: assert property (
    cpu_rd && ctl |=> (cpu_rdata & 8'h41) == 8'h00)
    else $error("control reads bad");
  a_hi_addr: assert property (
    cpu_rd && hi |=> cpu_rdata[7:2] == 6'h00)
    else $error("address high too wide");
endmodule
bind eac_nv_access eac_nv_access_sva i_eac_nv_access_sva (
  .clock, .rst, .por, .cpu_addr, .cpu_io_space, .cpu_wr, .cpu_rd, .cpu_wdata,
  .cpu_bit_set, .cpu_bit_sel, .global_irq_enable, .cpu_rdata, .cpu_stall, .nv_ready_irq);

// *** test/tb_top.sv ***
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       por = 1'b1;
  logic       global_irq_enable = 1'b1;
  logic [7:0] v;
  int         errors = 0, checks_done = 0, cycles = 0, n;
  wire  [7:0] cpu_addr, cpu_wdata, cpu_rdata;
  wire  [2:0] cpu_bit_sel;
  wire        cpu_io_space, cpu_wr, cpu_rd, cpu_bit_set, cpu_bit_clr, cpu_bit_test;
  wire        bit_test_hit, cpu_stall, nv_ready_irq;
  always #2.5 clock = ~clock;
  // short counts keep each split program near sixty cycles, an atomic one near eighty
  eac_nv_access #(.ATOMIC_TICKS(20'h28), .SPLIT_TICKS(20'h1e), .OSC_DIV(8'h2)) i_eac_nv_access (
    .clock, .rst, .por, .cpu_addr, .cpu_io_space, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_bit_set, .cpu_bit_clr, .cpu_bit_test, .cpu_bit_sel, .global_irq_enable,
    .cpu_rdata, .bit_test_hit, .cpu_stall, .nv_ready_irq);
  eac_cpu i_eac_cpu (.clock, .cpu_stall, .cpu_rdata, .cpu_addr, .cpu_io_space, .cpu_wr,
    .cpu_rd, .cpu_wdata, .cpu_bit_set, .cpu_bit_clr, .cpu_bit_test, .cpu_bit_sel);
  // ==========================================
  // helpers
  task automatic io(input int k, input logic [7:0] d);
    i_eac_cpu.op(k, 1'b1, 8'h1f, d);
  endtask
  task automatic rdv(input logic s, input logic [7:0] a);
    i_eac_cpu.rd(s, a, v);
  endtask
  task automatic stall_len;
    n = i_eac_cpu.stall_n;
  endtask
  task automatic wait_idle;
    int k = 0;
    do begin
      rdv(1'b1, 8'h1f);
      k++;
    end while (v[1] !== 1'b0 && k < 100);
    `CHK(v[1], 1'b0)
  endtask
  task automatic pulse_rst;
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // ==========================================
  // scenarios
  task automatic t_write;
    rdv(1'b0, 8'h3f);
    `CHK(v, 8'h00)
    i_eac_cpu.prog(10'h3ff, 8'h5a, 2'h0);
    stall_len();
    `CHK(n, 2)
    wait_idle();
    `CHK(v, 8'h80)
    io(0, 8'h00);
    rdv(1'b1, 8'h1f);
    `CHK(v, 8'h80)
    io(0, 8'h80);
    rdv(1'b1, 8'h1f);
    `CHK(v, 8'h00)
    io(2, 8'h00);
    stall_len();
    `CHK(n, 4)
    rdv(1'b1, 8'h20);
    `CHK(v, 8'h5a)
  endtask
  task automatic t_modes;
    logic [7:0] dt [4] = '{8'ha5, 8'h00, 8'h3c, 8'h00};
    logic [7:0] ex [4] = '{8'ha5, 8'hff, 8'h3c, 8'h3c};
    for (int i = 0; i < 4; i++) begin
      i_eac_cpu.prog(10'h000, dt[i], 2'(i));
      stall_len();
      `CHK(n, i == 3 ? 0 : 2)
      wait_idle();
      io(2, 8'h00);
      rdv(1'b0, 8'h40);
      `CHK(v, ex[i])
    end
  endtask
  task automatic t_arm;
    io(2, 8'h02);
    repeat (4) @(negedge clock);
    io(2, 8'h01);
    stall_len();
    `CHK(n, 0)
    io(2, 8'h01);
    stall_len();
    `CHK(n, 0)
    rdv(1'b1, 8'h1f);
    `CHK(v & 8'h06, 8'h00)
  endtask
  task automatic t_busy;
    i_eac_cpu.prog(10'h000, 8'h11, 2'h2);
    io(0, 8'h02);
    rdv(1'b1, 8'h1f);
    `CHK(v & 8'h32, 8'h22)
    pulse_rst();
    rdv(1'b1, 8'h1f);
    `CHK(v & 8'h32, 8'h22)
    wait_idle();
    io(2, 8'h00);
    rdv(1'b0, 8'h40);
    `CHK(v, 8'h10)
    pulse_rst();
    rdv(1'b1, 8'h1f);
    `CHK(v, 8'h00)
  endtask
  task automatic t_bits;
    io(2, 8'h03);
    rdv(1'b1, 8'h1f);
    `CHK(v, 8'h08)
    io(4, 8'h03);
    @(negedge clock);
    `CHK(bit_test_hit, 1'b1)
    `CHK(nv_ready_irq, 1'b1)
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(nv_ready_irq, 1'b0)
    global_irq_enable = 1'b1;
    io(3, 8'h03);
    io(4, 8'h03);
    @(negedge clock);
    `CHK(bit_test_hit, 1'b0)
    i_eac_cpu.op(0, 1'b1, 8'h22, 8'hff);
    rdv(1'b0, 8'h42);
    `CHK(v, 8'h03)
    rdv(1'b1, 8'h60);
    `CHK(v, 8'h00)
  endtask
  task automatic end_of_test;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock);
    {rst, por} = 2'h0;
    t_write();
    t_modes();
    t_arm();
    t_busy();
    t_bits();
    end_of_test();
  end
  // a hang counts as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
endmodule
